/* File: test/pcfg_pin_model.sv */
// pcfg_pin_model: pads and far-side drivers of the port pin block.
// assumes oe high while the block drives; an undriven pad floats.
`timescale 1ns/10ps
module pcfg_pin_model
  import pcfg_pkg::*;
(
  // clock
  input wire logic i_clk_sys,
  // block pad outputs
  input wire logic [4:0][7:0] i_out,
  input wire logic [4:0][7:0] i_oe,
  input wire logic [5:0][7:0] i_pu,
  // far-side drivers
  input wire logic [6:0][7:0] i_ext,
  input wire logic [6:0][7:0] i_ext_en,
  // resolved pad levels
  output logic [6:0][7:0] o_pin
);
  logic [7:0] flt = 8'h5a;
  wire logic [6:0][7:0] oe = {16'h0, i_oe};
  wire logic [6:0][7:0] pu = {8'h0, i_pu} & ~i_ext_en;
  wire logic [6:0][7:0] fl = ~oe & ~i_ext_en & ~pu;
  // a floating pad flips each cycle so a stale level never reads right
  always @(posedge i_clk_sys)
    flt <= ~flt;
  assign o_pin = (oe & {16'h0, i_out}) | (~oe & i_ext_en & i_ext)
    | (~oe & pu) | (fl & {7{flt}});
endmodule

/* File: test/pcfg_port_pins_monitor.sv */
// pcfg_port_pins_monitor: port-level assertions for the port pin block.
// assumes one clock domain and the block's active-low async reset.
`timescale 1ns/10ps
module pcfg_port_pins_monitor
  import pcfg_pkg::*;
#(
  parameter bit LARGE_PART = 1'b0
)
(
  // clock, reset and bus handshake
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  // pads and side outputs
  input wire logic [6:0][7:0] i_pin,
  input wire logic [4:0][7:0] o_pin_out,
  input wire logic [4:0][7:0] o_pin_oe,
  input wire logic [5:0][7:0] o_pullup_en,
  input wire logic [4:0][7:0] o_analog_en,
  input wire logic [3:0] o_p2_convert,
  input wire logic i_reset_pin_strap,
  input wire logic o_reset_hold
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  wire logic [39:0] an_map = LARGE_PART ? 40'h00000f0003 : 40'h00060f1f00;

  a_bus_one_wait: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not after one wait state");
  a_conv_pick: assert property (
    $onehot0(o_p2_convert)
    && (o_p2_convert & (~o_analog_en[2][3:0] | o_pin_oe[2][3:0])) == 4'h0)
    else $error("converted pin is not a lone analog input");
  a_pullup_input: assert property (
    (o_pullup_en[4:0] & o_pin_oe) == 40'h0)
    else $error("pull-up on a driven pin");
  a_analog_quiet: assert property (
    (o_analog_en & o_pin_oe) == 40'h0)
    else $error("analog pin driven");
  a_p6_od: assert property (
    o_pin_out[4][1:0] == 2'h0)
    else $error("p6 drives high");
  a_reset_map: assert property (
    $rose(i_nrst) |-> o_analog_en == an_map && o_pin_oe == 40'h0)
    else $error("reset pin map wrong");
  a_pu_flag: assert property (
    o_pullup_en[5][5] |-> i_reset_pin_strap)
    else $error("p12 pull-up without reset function");
  a_hold_sets: assert property (
    (i_reset_pin_strap && !i_pin[5][5]) [*6] |=> o_reset_hold)
    else $error("low reset pin does not hold reset");
  a_hold_clear: assert property (
    (i_pin[5][5] || !i_reset_pin_strap) [*6] |=> !o_reset_hold)
    else $error("reset held without low reset pin");

  c_hold: cover property (o_reset_hold);
  c_conv: cover property (o_p2_convert != 4'h0);
  c_write: cover property (i_avs_write && !o_avs_waitrequest);
endmodule

bind pcfg_port_pins pcfg_port_pins_monitor #(.LARGE_PART(LARGE_PART)) i_mon (.*);

/* File: test/pcfg_port_pins_tb.sv */
// pcfg_port_pins_tb: register and pad tests of the port pin block.
// assumes the small part map, the pin model and the bound monitor.
`timescale 1ns/10ps
module pcfg_port_pins_tb
  import pcfg_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic strap = 1'b1;
  logic [5:0] adr = 6'h00;
  logic wrq = 1'b0;
  logic rdq = 1'b0;
  logic [3:0] be = 4'h1;
  logic [31:0] wdat = 32'h0;
  logic [6:0][7:0] ext = 56'h80200000001f00;
  logic [6:0][7:0] ext_en = 56'h80ff0000001f00;
  logic [31:0] rdata, rdat;
  logic wreq, hold;
  logic [6:0][7:0] pin;
  logic [5:0][7:0] pu;
  logic [4:0][7:0] pout, poe, ttl, anl;
  logic [3:0] conv;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;

  always #2 clk = ~clk;

  pcfg_port_pins #(.LARGE_PART(1'b0)) i_pcfg_port_pins (
    .i_clk_sys(clk), .i_nrst(nrst), .i_avs_address(adr),
    .i_avs_read(rdq), .i_avs_write(wrq), .i_avs_writedata(wdat),
    .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_pin(pin), .o_pin_out(pout),
    .o_pin_oe(poe), .o_pullup_en(pu), .o_ttl_sel(ttl),
    .o_analog_en(anl), .o_p2_convert(conv),
    .i_reset_pin_strap(strap), .o_reset_hold(hold));

  pcfg_pin_model i_pcfg_pin_model (
    .i_clk_sys(clk), .i_out(pout), .i_oe(poe), .i_pu(pu),
    .i_ext(ext), .i_ext_en(ext_en), .o_pin(pin));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      stop_test;
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // request holds until waitrequest is seen low; one idle edge follows
  task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d);
    adr <= a;
    wrq <= w;
    rdq <= !w;
    wdat <= {24'h0, d};
    do
      @(posedge clk);
    while (wreq !== 1'b0);
    rdat = rdata;
    wrq <= 1'b0;
    rdq <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rc(input logic [5:0] a, input logic [31:0] e, input string n);
    bus(a, 1'b0, 8'h00);
    chk(n, e, rdat);
  endtask

  // pin inputs pass a synchroniser before they reach reads
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 5; k++)
      rc(6'h08 + 6'(k), 32'hff, "dir");
    rc(6'h29, 32'h1f, "an p1");
    rc(6'h2b, 32'h06, "an p4");
    rc(6'h30, 32'h4, "cfg");
    rc(6'h32, 32'h1, "flag");
    rc(6'h01, 32'h0, "p1 data");
    bus(6'h3f, 1'b1, 8'hff);
    rc(6'h3f, 32'h0, "unmapped");
    ext[0] <= 8'h0a;
    ext_en[0] <= 8'h0a;
    bus(6'h08, 1'b1, 8'hfa);
    bus(6'h00, 1'b1, 8'h05);
    settle;
    chk("oe p0", 32'h05, poe[0]);
    be <= 4'he;
    bus(6'h00, 1'b1, 8'h00);
    be <= 4'h1;
    rc(6'h00, 32'h0f, "p0 data");
    bus(6'h10, 1'b1, 8'hff);
    settle;
    chk("pu p0", 32'h0a, pu[0]);
    rc(6'h10, 32'h0f, "pu reg");
    ext_en[0] <= 8'h08;
    bus(6'h18, 1'b1, 8'h02);
    bus(6'h08, 1'b1, 8'hf8);
    bus(6'h00, 1'b1, 8'h07);
    settle;
    chk("oe od", 32'h05, poe[0]);
    bus(6'h00, 1'b1, 8'h05);
    settle;
    chk("oe od", 32'h07, poe[0]);
    chk("out od", 32'h05, pout[0]);
    bus(6'h0c, 1'b1, 8'hfc);
    bus(6'h04, 1'b1, 8'h01);
    bus(6'h21, 1'b1, 8'hff);
    bus(6'h29, 1'b1, 8'h1e);
    settle;
    chk("oe p6", 32'h02, poe[4]);
    chk("ttl p1", 32'h03, ttl[1]);
    chk("an p1", 32'h1e, anl[1]);
    rc(6'h01, 32'h01, "p1 data");
    for (int i = 0; i < 4; i++)
    begin
      bus(6'h31, 1'b1, 8'(i));
      settle;
      chk("conv", 32'h1 << i, conv);
    end
    bus(6'h30, 1'b1, 8'h02);
    bus(6'h0a, 1'b1, 8'hf7);
    bus(6'h02, 1'b1, 8'h08);
    ext[2] <= 8'h04;
    ext_en[2] <= 8'h04;
    settle;
    chk("conv", 32'h0, conv);
    chk("an p2", 32'h03, anl[2]);
    chk("oe p2", 32'h08, poe[2]);
    rc(6'h02, 32'h0c, "p2 data");
    ext[5] <= 8'hff;
    bus(6'h05, 1'b1, 8'h00);
    bus(6'h15, 1'b1, 8'h20);
    settle;
    rc(6'h05, 32'h26, "p12 data");
    rc(6'h06, 32'h80, "p13 data");
    chk("pu p12", 32'h20, pu[5]);
    ext[5] <= 8'h00;
    repeat (10) @(posedge clk);
    chk("hold", 32'h1, hold);
    ext[5] <= 8'h20;
    repeat (10) @(posedge clk);
    chk("hold", 32'h0, hold);
    nrst <= 1'b0;
    strap <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    ext[5] <= 8'h00;
    @(posedge clk);
    rc(6'h32, 32'h0, "flag");
    bus(6'h15, 1'b1, 8'h20);
    repeat (10) @(posedge clk);
    chk("pu p12", 32'h0, pu[5]);
    chk("hold", 32'h0, hold);
    stop_test;
  end
endmodule

/* File: verilog/pcfg_pkg.sv */
// pcfg_pkg: constants, pin bundle and state types for the port pin block.
// assumes one 250 MHz system clock; register bus index is a word index.
package pcfg_pkg;
  localparam int PCFG_NPORT = 7;
  localparam int PCFG_NIO = 5;
  // port slots: 0 p0, 1 p1, 2 p2, 3 p4, 4 p6, 5 p12, 6 p13
  localparam int PCFG_P2 = 2;
  localparam int PCFG_P12 = 5;
  localparam int PCFG_RST_BIT = 5;
  localparam int PCFG_P2_PINS = 4;

  // register index = kind * 8 + port slot
  localparam logic [2:0] PCFG_K_DATA = 3'h0;
  localparam logic [2:0] PCFG_K_DIR = 3'h1;
  localparam logic [2:0] PCFG_K_PU = 3'h2;
  localparam logic [2:0] PCFG_K_OD = 3'h3;
  localparam logic [2:0] PCFG_K_TTL = 3'h4;
  localparam logic [2:0] PCFG_K_AN = 3'h5;
  localparam logic [5:0] PCFG_CFG_IDX = 6'h30;
  localparam logic [5:0] PCFG_CHAN_IDX = 6'h31;
  localparam logic [5:0] PCFG_FLAG_IDX = 6'h32;

  // per-slot bit maps, slot 6 first
  localparam logic [6:0][7:0] PCFG_SM_IMPL =
    {8'h80, 8'h26, 8'h03, 8'h07, 8'h0f, 8'h1f, 8'h0f};
  localparam logic [6:0][7:0] PCFG_LG_IMPL =
    {8'h80, 8'h06, 8'h03, 8'h01, 8'h0f, 8'hff, 8'h03};
  localparam logic [6:0][7:0] PCFG_SM_PU =
    {8'h00, 8'h20, 8'h00, 8'h07, 8'h00, 8'h1f, 8'h0f};
  localparam logic [6:0][7:0] PCFG_LG_PU =
    {8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'hff, 8'h03};
  localparam logic [6:0][7:0] PCFG_SM_OD =
    {8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h07, 8'h02};
  localparam logic [6:0][7:0] PCFG_LG_OD =
    {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hbf, 8'h01};
  localparam logic [6:0][7:0] PCFG_FIXED_OD =
    {8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [6:0][7:0] PCFG_SM_TTL =
    {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
  localparam logic [6:0][7:0] PCFG_LG_TTL =
    {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hfb, 8'h02};
  localparam logic [6:0][7:0] PCFG_SM_AN =
    {8'h00, 8'h00, 8'h00, 8'h06, 8'h00, 8'h1f, 8'h00};
  localparam logic [6:0][7:0] PCFG_LG_AN =
    {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};

  localparam logic [7:0] PCFG_DIR_RST = 8'hff;
  localparam logic [2:0] PCFG_CFG_RST = 3'h4;
  localparam logic [3:0] PCFG_CHAN_RST = 4'h0;
  localparam logic PCFG_FLAG_RST = 1'b1;

  typedef struct packed {
    logic [4:0][7:0] out;
    logic [4:0][7:0] oe;
    logic [5:0][7:0] pu;
    logic [4:0][7:0] ttl;
    logic [4:0][7:0] an;
  } pcfg_pins_t;

  typedef struct packed {
    logic [6:0][7:0] s1;
    logic [6:0][7:0] s2;
    logic [6:0][7:0] s3;
    logic [6:0][7:0] filt;
    logic [4:0][7:0] latch;
    logic [4:0][7:0] dir;
    logic [5:0][7:0] pu;
    logic [4:0][7:0] od;
    logic [4:0][7:0] ttl;
    logic [4:0][7:0] an;
    logic [2:0] pin_cfg;
    logic [3:0] chan;
    logic flag;
    logic strap_done;
    logic waitreq;
    logic [31:0] rdata;
    pcfg_pins_t pins;
    logic [3:0] conv;
    logic rst_hold;
  } pcfg_state_t;
endpackage

/* File: verilog/pcfg_port_pins.sv */
// pcfg_port_pins: digital port pins with per-bit direction, latch, pull-up,
// open-drain, ttl input and analog selection, behind an avalon-mm slave.
// assumes pads resolve out/oe outside; pin inputs are asynchronous.
`timescale 1ns/10ps
module pcfg_port_pins
  import pcfg_pkg::*;
#(
  parameter bit LARGE_PART = 1'b0
)
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // avalon-mm slave, word addressed
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // pads
  input wire logic [6:0][7:0] i_pin,
  output logic [4:0][7:0] o_pin_out,
  output logic [4:0][7:0] o_pin_oe,
  output logic [5:0][7:0] o_pullup_en,
  output logic [4:0][7:0] o_ttl_sel,
  output logic [4:0][7:0] o_analog_en,
  // converter and reset controller
  output logic [3:0] o_p2_convert,
  input wire logic i_reset_pin_strap,
  output logic o_reset_hold
);

  localparam logic [6:0][7:0] IMPL = LARGE_PART ? PCFG_LG_IMPL
                                                : PCFG_SM_IMPL;
  localparam logic [6:0][7:0] PU_M = LARGE_PART ? PCFG_LG_PU : PCFG_SM_PU;
  localparam logic [6:0][7:0] OD_M = LARGE_PART ? PCFG_LG_OD : PCFG_SM_OD;
  localparam logic [6:0][7:0] TTL_M = LARGE_PART ? PCFG_LG_TTL
                                                 : PCFG_SM_TTL;
  localparam logic [6:0][7:0] AN_M = LARGE_PART ? PCFG_LG_AN : PCFG_SM_AN;

  // analog pins of p2 form a block from bit 0 upward
  function automatic logic [3:0] p2_analog(input logic [2:0] cfg);
    logic [3:0] r;
    r = '0;
    for (int i = 0; i < PCFG_P2_PINS; i++)
    begin
      r[i] = (3'(i) < cfg);
    end
    return r;
  endfunction

  // analog selection of one i/o slot, with p2 taken from the converter map
  function automatic logic [7:0] an_eff(input pcfg_state_t s, input int p);
    logic [7:0] r;
    r = s.an[p];
    if (p == PCFG_P2)
    begin
      r = {4'h0, p2_analog(s.pin_cfg)};
    end
    return r;
  endfunction

  function automatic pcfg_state_t rst_state();
    pcfg_state_t r;
    r = '0;
    // synchroniser starts at the idle-high level of the reset pin, so
    // release does not raise a false hold before the stages fill
    r.s1 = '1;
    r.s2 = '1;
    r.s3 = '1;
    r.filt = '1;
    for (int p = 0; p < PCFG_NIO; p++)
    begin
      r.dir[p] = PCFG_DIR_RST;
      r.an[p] = AN_M[p];
      r.pins.an[p] = AN_M[p];
    end
    r.pin_cfg = PCFG_CFG_RST;
    r.pins.an[PCFG_P2] = {4'h0, p2_analog(PCFG_CFG_RST)};
    r.chan = PCFG_CHAN_RST;
    r.flag = PCFG_FLAG_RST;
    r.waitreq = 1'b1;
    return r;
  endfunction

  localparam pcfg_state_t ST_RST = rst_state();

  pcfg_state_t st;
  pcfg_state_t next_st;

  logic req;
  logic wr_go;
  logic [2:0] kind;
  logic [2:0] slot;
  logic [7:0] wd;
  logic [7:0] rd;
  logic [7:0] an_now;
  logic [7:0] odm;
  logic [7:0] is_out;
  logic [3:0] p2_an;

  always_comb
  begin
    next_st = st;
    req = i_avs_read | i_avs_write;
    kind = i_avs_address[5:3];
    slot = i_avs_address[2:0];
    wd = i_avs_writedata[7:0];
    // only the low lane carries data; other lanes are ignored
    wr_go = i_avs_write & ~st.waitreq & i_avs_byteenable[0];
    rd = '0;
    an_now = '0;
    odm = '0;
    is_out = '0;
    p2_an = p2_analog(st.pin_cfg);

    // three-stage pin synchroniser, change accepted when stages 2,3 agree
    next_st.s1 = i_pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.filt = (st.s2 & st.s3) | (st.filt & (st.s2 ^ st.s3));

    // option flag is taken once, after reset release
    if (!st.strap_done)
    begin
      next_st.flag = i_reset_pin_strap;
      next_st.strap_done = 1'b1;
    end

    // one wait state: drop waitrequest, then complete and raise it again
    next_st.waitreq = ~(req & st.waitreq);

    // register writes
    for (int p = 0; p < PCFG_NPORT; p++)
    begin
      if (wr_go && slot == 3'(p))
      begin
        if (p < PCFG_NIO)
        begin
          unique case (kind)
            PCFG_K_DATA: next_st.latch[p] = wd & IMPL[p];
            PCFG_K_DIR: next_st.dir[p] = wd | ~IMPL[p];
            PCFG_K_PU: next_st.pu[p] = wd & PU_M[p];
            PCFG_K_OD: next_st.od[p] = wd & OD_M[p];
            PCFG_K_TTL: next_st.ttl[p] = wd & TTL_M[p];
            PCFG_K_AN: next_st.an[p] = wd & AN_M[p];
            default: ;
          endcase
        end
        else if (p == PCFG_P12 && kind == PCFG_K_PU)
        begin
          next_st.pu[p] = wd & PU_M[p];
        end
      end
    end
    if (wr_go && i_avs_address == PCFG_CFG_IDX)
    begin
      next_st.pin_cfg = wd[2:0];
    end
    if (wr_go && i_avs_address == PCFG_CHAN_IDX)
    begin
      next_st.chan = wd[3:0];
    end

    // read data is built in the cycle that drops waitrequest
    for (int p = 0; p < PCFG_NPORT; p++)
    begin
      if (slot == 3'(p))
      begin
        if (p < PCFG_NIO)
        begin
          an_now = an_eff(st, p);
          unique case (kind)
            PCFG_K_DATA:
              rd = ((st.dir[p] & st.filt[p] & ~an_now)
                   | (~st.dir[p] & st.latch[p])) & IMPL[p];
            PCFG_K_DIR: rd = st.dir[p];
            PCFG_K_PU: rd = st.pu[p];
            PCFG_K_OD: rd = st.od[p];
            PCFG_K_TTL: rd = st.ttl[p];
            PCFG_K_AN: rd = st.an[p];
            default: rd = '0;
          endcase
        end
        else if (kind == PCFG_K_DATA)
        begin
          rd = st.filt[p] & IMPL[p];
        end
        else if (p == PCFG_P12 && kind == PCFG_K_PU)
        begin
          rd = st.pu[p];
        end
      end
    end
    if (i_avs_address == PCFG_CFG_IDX)
    begin
      rd = {5'h00, st.pin_cfg};
    end
    else if (i_avs_address == PCFG_CHAN_IDX)
    begin
      rd = {4'h0, st.chan};
    end
    else if (i_avs_address == PCFG_FLAG_IDX)
    begin
      rd = {7'h00, st.flag};
    end
    if (req && st.waitreq)
    begin
      next_st.rdata = {24'h000000, rd};
    end

    // pad controls, registered from the current configuration
    for (int p = 0; p < PCFG_NIO; p++)
    begin
      an_now = an_eff(st, p);
      // analog with output direction is not allowed; keep the driver off
      is_out = ~st.dir[p] & ~an_now & IMPL[p];
      odm = st.od[p] | PCFG_FIXED_OD[p];
      next_st.pins.oe[p] = is_out & (~odm | ~st.latch[p]);
      next_st.pins.out[p] = st.latch[p] & ~odm;
      next_st.pins.pu[p] = st.pu[p] & st.dir[p] & ~an_now;
      next_st.pins.ttl[p] = st.ttl[p];
      next_st.pins.an[p] = an_now;
    end
    next_st.pins.pu[PCFG_P12] = st.pu[PCFG_P12]
                              & {2'h0, st.flag, 5'h00};

    for (int i = 0; i < PCFG_P2_PINS; i++)
    begin
      next_st.conv[i] = p2_an[i]
                      & st.dir[PCFG_P2][i] & (st.chan == 4'(i));
    end

    // low on the reset pin keeps the device in reset while selected
    next_st.rst_hold = st.flag & ~st.filt[PCFG_P12][PCFG_RST_BIT];
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st <= ST_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_avs_readdata = st.rdata;
  assign o_avs_waitrequest = st.waitreq;
  assign o_pin_out = st.pins.out;
  assign o_pin_oe = st.pins.oe;
  assign o_pullup_en = st.pins.pu;
  assign o_ttl_sel = st.pins.ttl;
  assign o_analog_en = st.pins.an;
  assign o_p2_convert = st.conv;
  assign o_reset_hold = st.rst_hold;

endmodule
